// ---- hdl/cc_pkg.sv ----
package cc_pkg;
    // command code of the conversion-control register
    localparam logic [7:0] CC_CMD_CODE      = 8'h01;
    localparam logic [7:0] CC_RESET_VALUE   = 8'h00;
    localparam int         CC_ON_BIT        = 7;
    localparam int         CC_SOFT_BIT      = 6;
    localparam int         CC_MARGIN_HI     = 5;
    localparam int         CC_MARGIN_LO     = 2;
    localparam int         CC_ENSRC_CMD_BIT = 3;
    localparam int         CC_HOLD_W        = 16;

    localparam logic [3:0] CC_MRG_OFF0      = 4'h0;
    localparam logic [3:0] CC_MRG_OFF1      = 4'h1;
    localparam logic [3:0] CC_MRG_OFF2      = 4'h2;
    localparam logic [3:0] CC_MRG_LOW_IGN   = 4'h5;
    localparam logic [3:0] CC_MRG_LOW_ACT   = 4'h6;
    localparam logic [3:0] CC_MRG_HIGH_IGN  = 4'h9;
    localparam logic [3:0] CC_MRG_HIGH_ACT  = 4'hA;

    // target select encoding
    localparam logic [1:0] CC_TGT_NOMINAL   = 2'h0;
    localparam logic [1:0] CC_TGT_LOW       = 2'h1;
    localparam logic [1:0] CC_TGT_HIGH      = 2'h2;

    typedef enum logic [3:0] {
        CC_ST_OFF  = 4'h1,
        CC_ST_ON   = 4'h2,
        CC_ST_HOLD = 4'h4,
        CC_ST_RAMP = 4'h8
    } cc_conv_e;
endpackage : cc_pkg

// ---- hdl/cc_conversion_control.sv ----
`timescale 1ns/100ps
// Contract
// - the register answers command code 01h, written by a byte write and read by a byte read.
// - bit 7 enables conversion when 1 and disables it when 0, and when 1 arms fault ignoring.
// - bit 7 alone never starts conversion; the power-good conditions must also hold.
// - bit 6 picks the turn-off profile on a command-driven 1-to-0 of bit 7 and is ignored while on.
// - with bit 6 at 0 turn-off stops conversion at once and puts the power stage in high-Z.
// - with bit 6 at 1 conversion holds for the turn-off delay, ramps to 0 V, then stops.
// - margin bits 5:2 reset to 0000b; codes 0, 1, 2 select nominal target and normal faults.
// - margin 0101b selects the low target and, with bit 7 set, OV/UV faults are ignored.
// - margin 0110b selects the low target with normal OV/UV fault action.
// - margin 1001b selects the high target and, with bit 7 set, OV/UV faults are ignored.
// - margin 1010b selects the high target with normal OV/UV fault action.
// - bits 1 and 0 always read zero whatever is written.
// - a write of an unlisted value is invalid data, flagged to status and answered to the host.
// - the on/off bit is obeyed only while bit 3 of the enable-source configuration is 1.
// - multi-byte values go byte 0 first into bits 7:0, each next byte eight bits higher.
module cc_conversion_control (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         link_clk,
    input  wire logic                         link_req,
    input  wire logic                         link_write,
    input  wire logic [7:0]                   link_cmd,
    input  wire logic [7:0]                   link_wdata,
    output logic                              link_busy,
    output logic                              link_ack,
    output logic                              link_nack,
    output logic [7:0]                        link_rdata,
    input  wire logic [7:0]                   enable_src_cfg,
    input  wire logic                         power_good,
    input  wire logic [cc_pkg::CC_HOLD_W-1:0] turnoff_hold_time,
    input  wire logic                         output_at_zero,
    output logic                              convert_en,
    output logic                              stage_hiz,
    output logic                              ramp_down,
    output logic [1:0]                        target_sel,
    output logic                              ovuv_ignore,
    output logic                              invalid_data
);
    import cc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // link domain: takes one byte transaction, passes it by toggle
    typedef struct packed {
        logic       rst_s1;
        logic       rst_s2;
        logic       req_tgl;
        logic       ack_s1;
        logic       ack_s2;
        logic       ack_s3;
        logic       busy;
        logic       write;
        logic [7:0] cmd;
        logic [7:0] wdata;
        logic       ack;
        logic       nack;
        logic [7:0] rdata;
    } cc_link_s;

    typedef struct packed {
        logic                 req_s1;
        logic                 req_s2;
        logic                 req_s3;
        logic                 ack_tgl;
        logic                 nack;
        logic [7:0]           rdata;
        logic [5:0]           stored;
        logic                 soft_latched;
        cc_conv_e             st;
        logic [CC_HOLD_W-1:0] hold_cnt;
        logic                 convert_en;
        logic                 stage_hiz;
        logic                 ramp_down;
        logic [1:0]           target_sel;
        logic                 ovuv_ignore;
        logic                 invalid_data;
    } cc_core_s;

    cc_link_s lnk_q;
    cc_link_s lnk_d;
    cc_core_s core_q;
    cc_core_s core_d;

    function automatic logic margin_valid(input logic [3:0] m);
        return m inside {CC_MRG_OFF0, CC_MRG_OFF1, CC_MRG_OFF2, CC_MRG_LOW_IGN,
                         CC_MRG_LOW_ACT, CC_MRG_HIGH_IGN, CC_MRG_HIGH_ACT};
    endfunction : margin_valid

    function automatic logic [1:0] margin_target(input logic [3:0] m);
        if (m == CC_MRG_LOW_IGN || m == CC_MRG_LOW_ACT) begin
            return CC_TGT_LOW;
        end
        if (m == CC_MRG_HIGH_IGN || m == CC_MRG_HIGH_ACT) begin
            return CC_TGT_HIGH;
        end
        return CC_TGT_NOMINAL;
    endfunction : margin_target

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        lnk_d        = lnk_q;
        lnk_d.rst_s1 = rst;
        lnk_d.rst_s2 = lnk_q.rst_s1;
        lnk_d.ack_s1 = core_q.ack_tgl;
        lnk_d.ack_s2 = lnk_q.ack_s1;
        lnk_d.ack_s3 = lnk_q.ack_s2;
        lnk_d.ack    = 1'b0;
        if (lnk_q.rst_s2) begin
            lnk_d.req_tgl = 1'b0;
            lnk_d.ack_s1  = 1'b0;
            lnk_d.ack_s2  = 1'b0;
            lnk_d.ack_s3  = 1'b0;
            lnk_d.busy    = 1'b0;
            lnk_d.write   = 1'b0;
            lnk_d.cmd     = 8'h00;
            lnk_d.wdata   = 8'h00;
            lnk_d.nack    = 1'b0;
            lnk_d.rdata   = 8'h00;
        end else if (lnk_q.busy) begin
            // cmd and wdata stay frozen until the answer returns
            if (lnk_q.ack_s2 != lnk_q.ack_s3) begin
                lnk_d.busy  = 1'b0;
                lnk_d.ack   = 1'b1;
                lnk_d.nack  = core_q.nack;
                lnk_d.rdata = core_q.rdata;
            end
        end else if (link_req) begin
            lnk_d.busy    = 1'b1;
            lnk_d.write   = link_write;
            lnk_d.cmd     = link_cmd;
            lnk_d.wdata   = link_wdata;
            lnk_d.req_tgl = ~lnk_q.req_tgl;
        end
    end

    always_ff @(posedge link_clk) begin
        lnk_q <= lnk_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // core domain
    logic       req_evt;
    logic       cmd_ctrl;
    logic       cmd_on;
    logic [7:0] new_val;
    logic       wr_ok;

    always_comb begin
        core_d        = core_q;
        core_d.req_s1 = lnk_q.req_tgl;
        core_d.req_s2 = core_q.req_s1;
        core_d.req_s3 = core_q.req_s2;
        req_evt       = core_q.req_s2 != core_q.req_s3;
        new_val       = lnk_q.wdata;
        wr_ok         = 1'b0;
        core_d.invalid_data = 1'b0;
        if (req_evt) begin
            core_d.ack_tgl = ~core_q.ack_tgl;
            core_d.nack    = 1'b0;
            core_d.rdata   = 8'h00;
            if (lnk_q.cmd != CC_CMD_CODE) begin
                core_d.nack = 1'b1;
            end else if (lnk_q.write) begin
                if (margin_valid(new_val[CC_MARGIN_HI:CC_MARGIN_LO])) begin
                    wr_ok = 1'b1;
                end else begin
                    core_d.nack         = 1'b1;
                    core_d.invalid_data = 1'b1;
                end
            end else begin
                core_d.rdata = {core_q.stored, 2'b00};
            end
        end
        if (wr_ok) begin
            core_d.stored = new_val[7:2];
        end

        // off command only counts while the command source is enabled
        cmd_ctrl = enable_src_cfg[CC_ENSRC_CMD_BIT];
        cmd_on   = cmd_ctrl ? core_d.stored[CC_ON_BIT-2] : 1'b1;
        unique case (core_q.st)
            CC_ST_OFF: begin
                if (cmd_on && power_good) begin
                    core_d.st = CC_ST_ON;
                end
            end
            CC_ST_ON: begin
                if (!power_good) begin
                    core_d.st = CC_ST_OFF;
                end else if (!cmd_on) begin
                    // profile read only at the falling edge of the on bit
                    core_d.soft_latched = core_d.stored[CC_SOFT_BIT-2];
                    core_d.st = core_d.stored[CC_SOFT_BIT-2] ? CC_ST_HOLD
                                                             : CC_ST_OFF;
                    core_d.hold_cnt = turnoff_hold_time;
                end
            end
            CC_ST_HOLD: begin
                if (!power_good) begin
                    core_d.st = CC_ST_OFF;
                end else if (core_q.hold_cnt == '0) begin
                    core_d.st = CC_ST_RAMP;
                end else begin
                    core_d.hold_cnt = core_q.hold_cnt - 1'b1;
                end
            end
            CC_ST_RAMP: begin
                if (output_at_zero || !power_good) begin
                    core_d.st = CC_ST_OFF;
                end
            end
        endcase
        core_d.convert_en = core_d.st != CC_ST_OFF;
        core_d.stage_hiz  = core_d.st == CC_ST_OFF;
        core_d.ramp_down  = core_d.st == CC_ST_RAMP;
        core_d.target_sel = margin_target(core_d.stored[3:0]);
        core_d.ovuv_ignore = core_d.stored[CC_ON_BIT-2] &&
            (core_d.stored[3:0] == CC_MRG_LOW_IGN ||
             core_d.stored[3:0] == CC_MRG_HIGH_IGN);
        if (rst) begin
            core_d        = '0;
            core_d.stored = CC_RESET_VALUE[7:2];
            core_d.st     = CC_ST_OFF;
            core_d.stage_hiz = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        core_q <= core_d;
    end

    ////////////////////////////////////////////////////////////////////////
    assign link_busy    = lnk_q.busy;
    assign link_ack     = lnk_q.ack;
    assign link_nack    = lnk_q.nack;
    assign link_rdata   = lnk_q.rdata;
    assign convert_en   = core_q.convert_en;
    assign stage_hiz    = core_q.stage_hiz;
    assign ramp_down    = core_q.ramp_down;
    assign target_sel   = core_q.target_sel;
    assign ovuv_ignore  = core_q.ovuv_ignore;
    assign invalid_data = core_q.invalid_data;
endmodule : cc_conversion_control

// ---- sim/cc_host_model.sv ----
`timescale 1ns/100ps
module cc_host_model (
    input  wire logic       link_clk,
    input  wire logic       link_busy,
    input  wire logic       link_ack,
    input  wire logic       link_nack,
    input  wire logic [7:0] link_rdata,
    output logic            link_req,
    output logic            link_write,
    output logic [7:0]      link_cmd,
    output logic [7:0]      link_wdata
);
    initial {link_req, link_write, link_cmd, link_wdata} = 18'h0;
    // one byte transaction; caller never overlaps, so one req cycle is taken
    task xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
              output logic [7:0] r, output logic n);
        int k;
        k = 0;
        @(posedge link_clk);
        {link_req, link_write, link_cmd, link_wdata} <= {1'b1, w, c, d};
        @(posedge link_clk);
        // released lines flip so a stale value is never mistaken for data
        {link_req, link_cmd, link_wdata} <= {1'b0, ~c, ~d};
        // answer taken at the rising edge that samples ack high
        do @(posedge link_clk); while (link_ack !== 1'b1 && ++k < 60);
        // no answer: unknown result so the caller's compare counts a mismatch
        r = (link_ack === 1'b1) ? link_rdata : 8'hXX;
        n = (link_ack === 1'b1) ? link_nack : 1'bx;
    endtask : xfer
endmodule : cc_host_model

// ---- sim/cc_conversion_control_sva.sv ----
`timescale 1ns/100ps
module cc_conv_sva (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       link_clk,
    input wire logic       link_busy,
    input wire logic       link_ack,
    input wire logic       power_good,
    input wire logic       output_at_zero,
    input wire logic       convert_en,
    input wire logic       stage_hiz,
    input wire logic       ramp_down,
    input wire logic [1:0] target_sel,
    input wire logic       ovuv_ignore,
    input wire logic       invalid_data
);
    chk_pg_loss_off: assert property (@(posedge clk) disable iff (rst)
        !power_good |=> !convert_en) else $error("conversion kept without power good");
    chk_rise_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(convert_en) |-> $past(power_good)) else $error("start without power good");
    chk_hiz_off: assert property (@(posedge clk) disable iff (rst)
        stage_hiz |-> !convert_en) else $error("high-z while converting");
    chk_ramp_conv: assert property (@(posedge clk) disable iff (rst)
        ramp_down |-> convert_en && !stage_hiz) else $error("ramp without conversion");
    chk_ramp_end: assert property (@(posedge clk) disable iff (rst)
        ramp_down && output_at_zero |-> ##[1:2] !convert_en) else $error("ramp did not stop");
    chk_ignore_margin: assert property (@(posedge clk) disable iff (rst)
        ovuv_ignore |-> target_sel inside {2'h1, 2'h2}) else $error("ignore at nominal");
    chk_target_legal: assert property (@(posedge clk) disable iff (rst)
        target_sel != 2'h3) else $error("target select out of range");
    chk_invalid_pulse: assert property (@(posedge clk) disable iff (rst)
        invalid_data |=> !invalid_data) else $error("invalid flag held");
    chk_ack_pulse: assert property (@(posedge link_clk) disable iff (rst)
        link_ack |=> !link_ack) else $error("answer longer than one cycle");
    chk_ack_not_busy: assert property (@(posedge link_clk) disable iff (rst)
        $fell(link_busy) |-> link_ack) else $error("busy dropped without answer");
    cov_ramp: cover property (@(posedge clk) $rose(ramp_down));
    cov_ignore: cover property (@(posedge clk) $rose(ovuv_ignore));
    cov_invalid: cover property (@(posedge clk) invalid_data);
endmodule : cc_conv_sva

// ---- sim/tb_conversion_control.sv ----
`timescale 1ns/100ps
module tb_conversion_control;
    import cc_pkg::*;
    logic        clk, rst, link_clk, link_req, link_write, link_busy, link_ack, link_nack;
    logic [7:0]  link_cmd, link_wdata, link_rdata, enable_src_cfg, rd;
    logic [15:0] turnoff_hold_time;
    logic        power_good, output_at_zero, convert_en, stage_hiz, ramp_down, nk;
    logic        ovuv_ignore, invalid_data;
    logic [1:0]  target_sel;
    logic [3:0]  codes [7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA};
    logic [1:0]  tgts [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    int          errors, check_count, cycles, inv_cnt;
    cc_conversion_control dut_u (.clk, .rst, .link_clk, .link_req, .link_write, .link_cmd,
        .link_wdata, .link_busy, .link_ack, .link_nack, .link_rdata, .enable_src_cfg,
        .power_good, .turnoff_hold_time, .output_at_zero, .convert_en, .stage_hiz,
        .ramp_down, .target_sel, .ovuv_ignore, .invalid_data);
    cc_host_model host_u (.link_clk, .link_busy, .link_ack, .link_nack, .link_rdata,
        .link_req, .link_write, .link_cmd, .link_wdata);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // link clock offset so its edges never line up with the core clock
    initial begin
        link_clk = 1'b0;
        #2.3;
        forever #7.5 link_clk = ~link_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task cb(input string s, input logic e, input logic g);
        chk(s, {7'h0, e}, {7'h0, g});
    endtask : cb
    task xf(input logic w, input logic [7:0] c, input logic [7:0] d);
        host_u.xfer(w, c, d, rd, nk);
        repeat (3) @(posedge clk);
    endtask : xf
    always @(posedge clk) begin
        cycles++;
        if (invalid_data === 1'b1) inv_cnt++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, enable_src_cfg, power_good, turnoff_hold_time, output_at_zero} =
            {1'b1, 8'h08, 1'b1, 16'h0028, 1'b0};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        xf(1'b0, CC_CMD_CODE, 8'h00);
        chk("reset value", CC_RESET_VALUE, rd);
        cb("reset hiz", 1'b1, stage_hiz);
        for (int i = 0; i < 7; i++) begin
            xf(1'b1, CC_CMD_CODE, {2'b10, codes[i], 2'b11});
            cb("write nack", 1'b0, nk);
            xf(1'b0, CC_CMD_CODE, 8'h00);
            chk("readback", {2'b10, codes[i], 2'b00}, rd);
            cb("busy idle", 1'b0, link_busy);
            chk("target", {6'h0, tgts[i]}, {6'h0, target_sel});
            cb("ignore", codes[i] == 4'h5 || codes[i] == 4'h9, ovuv_ignore);
            cb("convert on", 1'b1, convert_en);
        end
        $display("margin test done");
        xf(1'b1, CC_CMD_CODE, 8'h8C);
        cb("invalid nack", 1'b1, nk);
        chk("invalid pulses", 8'h01, inv_cnt[7:0]);
        xf(1'b0, CC_CMD_CODE, 8'h00);
        chk("kept value", 8'hA8, rd);
        xf(1'b0, 8'h02, 8'h00);
        cb("unknown nack", 1'b1, nk);
        $display("invalid test done");
        power_good <= 1'b0;
        repeat (3) @(posedge clk);
        cb("lockout", 1'b0, convert_en);
        power_good <= 1'b1;
        enable_src_cfg <= 8'h00;
        xf(1'b1, CC_CMD_CODE, 8'h00);
        cb("command ignored", 1'b1, convert_en);
        enable_src_cfg <= 8'h08;
        xf(1'b1, CC_CMD_CODE, 8'h00);
        cb("hard off", 1'b0, convert_en);
        cb("hard off hiz", 1'b1, stage_hiz);
        power_good <= 1'b0;
        xf(1'b1, CC_CMD_CODE, 8'h80);
        cb("no start", 1'b0, convert_en);
        power_good <= 1'b1;
        repeat (3) @(posedge clk);
        cb("start", 1'b1, convert_en);
        $display("on off test done");
        xf(1'b1, CC_CMD_CODE, 8'h40);
        cb("soft hold", 1'b1, convert_en);
        cb("soft no ramp", 1'b0, ramp_down);
        repeat (60) @(posedge clk);
        cb("soft ramp", 1'b1, ramp_down);
        output_at_zero <= 1'b1;
        repeat (3) @(posedge clk);
        cb("soft stop", 1'b0, convert_en);
        $display("soft off test done");
        print_verdict();
    end
endmodule : tb_conversion_control
bind cc_conversion_control cc_conv_sva chk_u (.clk, .rst, .link_clk, .link_busy, .link_ack,
    .power_good, .output_at_zero, .convert_en, .stage_hiz, .ramp_down, .target_sel,
    .ovuv_ignore, .invalid_data);
